// File: pkg/csd_params.svh
// Constants for the cycle-steal descriptor engine.
`ifndef CSD_PARAMS_SVH
`define CSD_PARAMS_SVH

// Control word bits, numbered with bit 15 as the most significant.
`define CSD_CW_CHAIN 15
`define CSD_CW_PCI 14
`define CSD_CW_SE 11
`define CSD_CW_BURST 0

// Word indices inside a transfer descriptor.
`define CSD_DW_CTRL 3'h0
`define CSD_DW_ID 3'h3
`define CSD_DW_SADDR 3'h4
`define CSD_DW_NEXT 3'h5
`define CSD_DW_COUNT 3'h6
`define CSD_DW_DADDR 3'h7
`define CSD_DW_LAST 3'h7

// Residual status block layout.
`define CSD_RSB_MAX_WORDS 8
`define CSD_RSB_EOC 15
`define CSD_RSB_NE 14

// Interrupt condition codes and status byte bit.
`define CSD_CC_PCI 3'h1
`define CSD_CC_EXC 3'h2
`define CSD_CC_END 3'h3
`define CSD_ISB_PDE 7

// Register byte addresses and fields.
`define CSD_REG_START 4'h0
`define CSD_REG_OPT 4'h4
`define CSD_REG_STATUS 4'h8
`define CSD_REG_RESID 4'hc
`define CSD_OPT_ILR 0
`define CSD_OPT_COD 1
`define CSD_OPT_RST 2'h0

// Channel clock and the highest allowed burst rate.
`define CSD_CLK_HZ 40000000
`define CSD_BURST_BPS 1332000
`define CSD_BYTES_PER_XFER 2

`endif

// File: pkg/csd_pkg.sv
// Types shared by the cycle-steal descriptor engine.
package csd_pkg;
  typedef enum logic [2:0] {
    CSD_IDLE   = 3'h0,
    CSD_FETCH  = 3'h1,
    CSD_DECODE = 3'h3,
    CSD_XFER   = 3'h2,
    CSD_RSB    = 3'h6,
    CSD_ENDD   = 3'h7,
    CSD_WIRQ   = 3'h5
  } csd_state_t;

  // Exception action type; code 0 on the device input means not suppressible.
  typedef enum logic [1:0] {
    CSD_ACT_NONE = 2'h0,
    CSD_ACT_CONT = 2'h1,
    CSD_ACT_TXFR = 2'h2,
    CSD_ACT_TCHN = 2'h3
  } csd_act_t;
endpackage : csd_pkg

// File: hw/csd_rate_gate.sv
// Spacing gate that keeps burst transfers under the channel rate limit.
`timescale 1ns/1ps
`include "csd_params.svh"
module csd_rate_gate import csd_pkg::*; #(
  parameter int CLK_HZ   = `CSD_CLK_HZ,
  parameter int RATE_BPS = `CSD_BURST_BPS,
  parameter int BYTES    = `CSD_BYTES_PER_XFER
) (
  input  wire logic mclk_i,
  input  wire logic rst_i,
  input  wire logic fire_i,
  output logic      ok_o
);
  // Least spacing rounds up to whole cycles.
  localparam int SPACING = (BYTES * CLK_HZ + RATE_BPS - 1) / RATE_BPS;
  localparam logic [7:0] LOAD = 8'(SPACING - 1);

  logic [7:0] cnt_q;

  assign ok_o = (cnt_q == 8'h00);

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      cnt_q <= 8'h00;
    end else if (fire_i) begin
      cnt_q <= LOAD;
    end else if (!ok_o) begin
      cnt_q <= cnt_q - 8'h01;
    end
  end
endmodule : csd_rate_gate

// File: hw/csd_irq_slot.sv
// Single interrupt slot; a newer condition replaces a pending one.
`timescale 1ns/1ps
`include "csd_params.svh"
module csd_irq_slot import csd_pkg::*; (
  input  wire logic       mclk_i,
  input  wire logic       rst_i,
  input  wire logic       set_i,
  input  wire logic [2:0] cc_i,
  input  wire logic [7:0] info_i,
  input  wire logic       ack_i,
  output logic            req_o,
  output logic [2:0]      cc_o,
  output logic [7:0]      info_o
);
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      req_o  <= 1'b0;
      cc_o   <= 3'h0;
      info_o <= 8'h00;
    end else if (set_i) begin
      // A new condition wins over an acknowledge in the same cycle.
      req_o  <= 1'b1;
      cc_o   <= cc_i;
      info_o <= info_i;
    end else if (ack_i) begin
      req_o  <= 1'b0;
    end
  end
endmodule : csd_irq_slot

// File: hw/csd_engine.sv
// Cycle-steal transfer engine driven by memory-resident transfer descriptors.
`timescale 1ns/1ps
`include "csd_params.svh"
module csd_engine import csd_pkg::*; #(
  parameter int RSB_WORDS = 2
) (
  input  wire logic        mclk_i,
  input  wire logic        rst_i,
  input  wire logic [3:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic [31:0]      avs_readdata_o,
  output logic             avs_waitrequest_o,
  output logic             cs_req_o,
  output logic             cs_we_o,
  output logic [15:0]      cs_addr_o,
  output logic [15:0]      cs_wdata_o,
  input  wire logic        cs_ack_i,
  input  wire logic        cs_err_i,
  input  wire logic [15:0] cs_rdata_i,
  output logic             burst_hold_o,
  output logic             irq_req_o,
  output logic [2:0]       irq_cc_o,
  output logic [7:0]       irq_info_o,
  input  wire logic        irq_ack_i,
  input  wire logic        dv_valid_i,
  input  wire logic [15:0] dv_data_i,
  output logic             dv_ready_o,
  input  wire logic        exc_valid_i,
  input  wire logic [1:0]  exc_type_i,
  input  wire logic [7:0]  exc_flags_i,
  input  wire logic        exc_short_ilr_i,
  input  wire logic        exc_cod_i
);
  localparam logic [2:0] RSB_LAST = 3'(RSB_WORDS - 1);

  csd_state_t  state_q, state_d;
  csd_act_t    act_q, act_d;
  logic [2:0]  idx_q, idx_d;
  logic [15:0] ctrl_q, ctrl_d, saddr_q, saddr_d, next_q, next_d;
  logic [15:0] cnt_q, cnt_d, daddr_q, daddr_d, dcb_q, dcb_d;
  logic [7:0]  id_q, id_d, flags_q, flags_d;
  logic        hard_q, hard_d, real_q, real_d, stop_q, stop_d, sup_q, sup_d;
  logic        req_q, req_d, we_q, we_d, burst_q;
  logic [15:0] addr_q, addr_d, wdata_q, wdata_d;
  logic [1:0]  opt_q;
  logic        ack_q;
  logic [31:0] rdata_q;
  logic        irq_set;
  logic [2:0]  irq_cc;
  logic [7:0]  irq_info;
  logic        take;

  // Register bus decode: one wait cycle, then the access completes.
  wire acc      = avs_read_i | avs_write_i;
  wire wr_done  = avs_write_i & ack_q;
  wire hit_start = avs_address_i == `CSD_REG_START;
  wire hit_opt   = avs_address_i == `CSD_REG_OPT;
  wire hit_stat  = avs_address_i == `CSD_REG_STATUS;
  wire hit_resid = avs_address_i == `CSD_REG_RESID;
  wire start_wr = wr_done & hit_start & (&avs_byteenable_i[1:0]) & (state_q == CSD_IDLE);
  wire busy     = state_q != CSD_IDLE;
  wire [31:0] stat_word = {24'h0, irq_cc_o, irq_req_o, burst_q, state_q[2:0]} & 32'h0000_00ff;
  wire [31:0] rd_mux = hit_start ? {16'h0, dcb_q} :
                       hit_opt   ? {30'h0, opt_q} :
                       hit_stat  ? (stat_word | {31'h0, busy}) :
                       hit_resid ? {daddr_q, cnt_q} : 32'h0;

  // Descriptor option decode.
  wire opt_chain = ctrl_q[`CSD_CW_CHAIN];
  wire opt_pci   = ctrl_q[`CSD_CW_PCI];
  wire opt_se    = ctrl_q[`CSD_CW_SE];
  wire opt_burst = ctrl_q[`CSD_CW_BURST];
  wire data_done = (cnt_q < 16'h0002) | stop_q;
  wire rate_ok;
  wire benign    = (exc_short_ilr_i & opt_q[`CSD_OPT_ILR]) |
                   (exc_cod_i & opt_q[`CSD_OPT_COD]);
  // With suppression on, a clean descriptor ends with a normal end instead of chaining.
  wire chain_go  = opt_chain & (act_q != CSD_ACT_TCHN) & (~opt_se | real_q);
  // End-of-chain is set unless this descriptor really chains onward.
  wire eoc       = ~chain_go | hard_q;
  wire [15:0] rsb_w1 = {eoc, ~real_q, 6'h00, flags_q};
  wire permissive_normal_end       = opt_se & sup_q;

  assign avs_waitrequest_o = acc & ~ack_q;
  assign avs_readdata_o    = rdata_q;
  assign cs_req_o          = req_q;
  assign cs_we_o           = we_q;
  assign cs_addr_o         = addr_q;
  assign cs_wdata_o        = wdata_q;
  assign burst_hold_o      = burst_q;
  assign dv_ready_o        = take;

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      ack_q   <= 1'b0;
      rdata_q <= 32'h0;
      opt_q   <= `CSD_OPT_RST;
    end else begin
      ack_q <= acc & ~ack_q;
      if (acc & ~ack_q) begin
        rdata_q <= rd_mux;
      end
      if (wr_done & hit_opt & avs_byteenable_i[0]) begin
        opt_q <= avs_writedata_i[1:0];
      end
    end
  end

  // Burst keeps the channel until the last data transfer has been acknowledged.
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      burst_q <= 1'b0;
    end else begin
      burst_q <= (state_d == CSD_XFER) & opt_burst;
    end
  end

  csd_rate_gate u_rate (
    .mclk_i (mclk_i),
    .rst_i  (rst_i),
    .fire_i (take),
    .ok_o   (rate_ok)
  );

  csd_irq_slot u_irq (
    .mclk_i (mclk_i),
    .rst_i  (rst_i),
    .set_i  (irq_set),
    .cc_i   (irq_cc),
    .info_i (irq_info),
    .ack_i  (irq_ack_i),
    .req_o  (irq_req_o),
    .cc_o   (irq_cc_o),
    .info_o (irq_info_o)
  );

  always_comb begin
    state_d  = state_q;
    act_d    = act_q;
    idx_d    = idx_q;
    ctrl_d   = ctrl_q;
    saddr_d  = saddr_q;
    next_d   = next_q;
    cnt_d    = cnt_q;
    daddr_d  = daddr_q;
    dcb_d    = dcb_q;
    id_d     = id_q;
    flags_d  = flags_q;
    hard_d   = hard_q;
    real_d   = real_q;
    stop_d   = stop_q;
    sup_d    = sup_q;
    req_d    = req_q;
    we_d     = we_q;
    addr_d   = addr_q;
    wdata_d  = wdata_q;
    irq_set  = 1'b0;
    irq_cc   = `CSD_CC_END;
    irq_info = 8'h00;
    take     = 1'b0;
    case (state_q)
      CSD_IDLE: begin
        if (start_wr) begin
          dcb_d   = avs_writedata_i[15:0];
          sup_d   = 1'b0;
          idx_d   = 3'h0;
          state_d = CSD_FETCH;
        end
      end
      CSD_FETCH: begin
        if (!req_q) begin
          req_d  = 1'b1;
          we_d   = 1'b0;
          addr_d = dcb_q + {12'h0, idx_q, 1'b0};
        end else if (cs_ack_i) begin
          req_d = 1'b0;
          if (cs_err_i) begin
            hard_d  = 1'b1;
            state_d = CSD_ENDD;
          end else begin
            case (idx_q)
              `CSD_DW_CTRL:  ctrl_d  = cs_rdata_i;
              `CSD_DW_ID:    id_d    = cs_rdata_i[7:0];
              `CSD_DW_SADDR: saddr_d = cs_rdata_i;
              `CSD_DW_NEXT:  next_d  = cs_rdata_i;
              `CSD_DW_COUNT: cnt_d   = cs_rdata_i;
              `CSD_DW_DADDR: daddr_d = cs_rdata_i;
              default:       ;
            endcase
            idx_d   = idx_q + 3'h1;
            state_d = (idx_q == `CSD_DW_LAST) ? CSD_DECODE : CSD_FETCH;
          end
        end
      end
      CSD_DECODE: begin
        if (opt_pci) begin
          irq_set  = 1'b1;
          irq_cc   = `CSD_CC_PCI;
          irq_info = id_q;
        end
        state_d = CSD_XFER;
      end
      CSD_XFER: begin
        if (req_q) begin
          if (cs_ack_i) begin
            req_d = 1'b0;
            if (cs_err_i) begin
              hard_d = 1'b1;
              stop_d = 1'b1;
            end else begin
              cnt_d   = cnt_q - 16'h0002;
              daddr_d = daddr_q + 16'h0002;
            end
          end
        end else if (data_done) begin
          idx_d   = 3'h0;
          state_d = (opt_se & ~hard_q) ? CSD_RSB : CSD_ENDD;
        end else if (dv_valid_i & rate_ok) begin
          take    = 1'b1;
          req_d   = 1'b1;
          we_d    = 1'b1;
          addr_d  = daddr_q;
          wdata_d = dv_data_i;
        end
      end
      CSD_RSB: begin
        if (!req_q) begin
          req_d   = 1'b1;
          we_d    = 1'b1;
          addr_d  = saddr_q + {12'h0, idx_q, 1'b0};
          wdata_d = (idx_q == 3'h0) ? cnt_q :
                    (idx_q == 3'h1) ? rsb_w1 : 16'h0000;
        end else if (cs_ack_i) begin
          req_d = 1'b0;
          idx_d = idx_q + 3'h1;
          if (cs_err_i) begin
            hard_d  = 1'b1;
            state_d = CSD_ENDD;
          end else if (idx_q == RSB_LAST) begin
            state_d = CSD_ENDD;
          end
        end
      end
      CSD_ENDD: begin
        if (hard_q) begin
          irq_set  = 1'b1;
          irq_cc   = `CSD_CC_EXC;
          irq_info = flags_q;
          state_d  = CSD_WIRQ;
        end else if (chain_go) begin
          dcb_d   = next_q;
          idx_d   = 3'h0;
          act_d   = CSD_ACT_NONE;
          flags_d = 8'h00;
          real_d  = 1'b0;
          stop_d  = 1'b0;
          state_d = CSD_FETCH;
        end else begin
          irq_set  = 1'b1;
          irq_cc   = `CSD_CC_END;
          irq_info = {permissive_normal_end, 7'h00};
          state_d  = CSD_WIRQ;
        end
      end
      CSD_WIRQ: begin
        if (!irq_req_o) begin
          act_d   = CSD_ACT_NONE;
          flags_d = 8'h00;
          hard_d  = 1'b0;
          real_d  = 1'b0;
          stop_d  = 1'b0;
          state_d = CSD_IDLE;
        end
      end
      default: begin
        state_d = CSD_IDLE;
      end
    endcase
    // Device exceptions count only while data moves; flags accumulate.
    if ((state_q == CSD_XFER) && exc_valid_i && !stop_q) begin
      flags_d = flags_d | exc_flags_i;
      if (benign) begin
        sup_d = sup_d;
      end else if (!opt_se || (exc_type_i == CSD_ACT_NONE)) begin
        hard_d = 1'b1;
        stop_d = 1'b1;
      end else begin
        sup_d  = 1'b1;
        real_d = 1'b1;
        if (exc_type_i > act_d) begin
          act_d = csd_act_t'(exc_type_i);
        end
        if (exc_type_i != CSD_ACT_CONT) begin
          stop_d = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      state_q <= CSD_IDLE;
      act_q   <= CSD_ACT_NONE;
      idx_q   <= 3'h0;
      ctrl_q  <= 16'h0000;
      saddr_q <= 16'h0000;
      next_q  <= 16'h0000;
      cnt_q   <= 16'h0000;
      daddr_q <= 16'h0000;
      dcb_q   <= 16'h0000;
      id_q    <= 8'h00;
      flags_q <= 8'h00;
      hard_q  <= 1'b0;
      real_q  <= 1'b0;
      stop_q  <= 1'b0;
      sup_q   <= 1'b0;
      req_q   <= 1'b0;
      we_q    <= 1'b0;
      addr_q  <= 16'h0000;
      wdata_q <= 16'h0000;
    end else begin
      state_q <= state_d;
      act_q   <= act_d;
      idx_q   <= idx_d;
      ctrl_q  <= ctrl_d;
      saddr_q <= saddr_d;
      next_q  <= next_d;
      cnt_q   <= cnt_d;
      daddr_q <= daddr_d;
      dcb_q   <= dcb_d;
      id_q    <= id_d;
      flags_q <= flags_d;
      hard_q  <= hard_d;
      real_q  <= real_d;
      stop_q  <= stop_d;
      sup_q   <= sup_d;
      req_q   <= req_d;
      we_q    <= we_d;
      addr_q  <= addr_d;
      wdata_q <= wdata_d;
    end
  end
endmodule : csd_engine

// File: test/csd_engine_asserts.sv
// Port-level checker for the cycle-steal descriptor engine.
`timescale 1ns/1ps
`include "csd_params.svh"
module csd_engine_asserts import csd_pkg::*; (
  input wire logic        mclk_i,
  input wire logic        rst_i,
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic        avs_waitrequest_o,
  input wire logic        cs_req_o,
  input wire logic        cs_we_o,
  input wire logic [15:0] cs_addr_o,
  input wire logic        cs_ack_i,
  input wire logic        burst_hold_o,
  input wire logic        irq_req_o,
  input wire logic [2:0]  irq_cc_o,
  input wire logic        irq_ack_i,
  input wire logic        dv_ready_o
);
  logic [6:0] gap_q;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  // Cycles since the last data word was taken, saturating at the minimum spacing.
  always_ff @(posedge mclk_i) begin
    if (rst_i || dv_ready_o) gap_q <= rst_i ? 7'h3d : 7'h01;
    else if (gap_q != 7'h3d) gap_q <= gap_q + 7'h01;
  end
  chk_wait_one: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("waitrequest held past one cycle");
  chk_rate_gap: assert property (dv_ready_o |-> gap_q == 7'h3d)
    else $error("data words taken too close together");
  chk_burst_keep: assert property (burst_hold_o && dv_ready_o |=> burst_hold_o)
    else $error("channel released while a burst word was in flight");
  chk_pci_fetch: assert property ($rose(irq_req_o) && irq_cc_o == `CSD_CC_PCI |->
                                  $past(cs_ack_i, 2) && !$past(cs_we_o, 2))
    else $error("program interrupt not raised right after a fetch");
  chk_irq_pend: assert property (irq_req_o && !irq_ack_i |=> irq_req_o)
    else $error("interrupt request withdrawn before acceptance");
  chk_irq_code: assert property (irq_req_o |-> irq_cc_o inside {`CSD_CC_PCI, `CSD_CC_EXC, `CSD_CC_END})
    else $error("illegal interrupt condition code");
  chk_req_hold: assert property (cs_req_o && !cs_ack_i |=> cs_req_o && $stable(cs_addr_o) && $stable(cs_we_o))
    else $error("cycle-steal request changed before acknowledge");
  chk_req_drop: assert property (cs_req_o && cs_ack_i |=> !cs_req_o)
    else $error("cycle-steal request kept after acknowledge");
  cover property ($rose(irq_req_o) && irq_cc_o == `CSD_CC_PCI);
  cover property (irq_req_o && irq_cc_o == `CSD_CC_EXC);
  cover property (burst_hold_o && dv_ready_o);
endmodule : csd_engine_asserts

bind csd_engine csd_engine_asserts chk_u (.mclk_i, .rst_i, .avs_read_i, .avs_write_i, .avs_waitrequest_o, .cs_req_o,
  .cs_we_o, .cs_addr_o, .cs_ack_i, .burst_hold_o, .irq_req_o, .irq_cc_o, .irq_ack_i, .dv_ready_o);

// File: test/csd_chan_model.sv
// Behavioural I/O channel and main storage facing the engine.
`timescale 1ns/1ps
module csd_chan_model (
  input  wire logic        mclk_i,
  input  wire logic        rst_i,
  input  wire logic        irq_hold_i,
  input  wire logic        err_en_i,
  input  wire logic        cs_req_i,
  input  wire logic        cs_we_i,
  input  wire logic [15:0] cs_addr_i,
  input  wire logic [15:0] cs_wdata_i,
  input  wire logic        burst_hold_i,
  input  wire logic        irq_req_i,
  output logic             cs_ack_o,
  output logic             cs_err_o,
  output logic [15:0]      cs_rdata_o,
  output logic             irq_ack_o
);
  logic [15:0] mem [0:1023];
  logic [1:0]  cnt_q;
  logic        slow_q;
  // Answers alternate between prompt and slow; read data wanders outside an acknowledge.
  always @(posedge mclk_i) begin
    if (rst_i) begin
      {cs_ack_o, cs_err_o, irq_ack_o, slow_q} <= 4'h0;
      cs_rdata_o <= 16'h0000;
      cnt_q      <= 2'h0;
    end else begin
      {cs_ack_o, cs_err_o, irq_ack_o} <= 3'h0;
      cs_rdata_o <= ~cs_rdata_o;
      if (cs_req_i && !cs_ack_o && slow_q && cnt_q != 2'h2) cnt_q <= cnt_q + 2'h1;
      else if (cs_req_i && !cs_ack_o) begin
        cnt_q    <= 2'h0;
        slow_q   <= !slow_q;
        cs_ack_o <= 1'b1;
        cs_err_o <= err_en_i && !cs_we_i;
        if (cs_we_i) mem[cs_addr_i[10:1]] <= cs_wdata_i;
        else cs_rdata_o <= mem[cs_addr_i[10:1]];
      end
      if (irq_req_i && !irq_ack_o && !irq_hold_i && !burst_hold_i) irq_ack_o <= 1'b1;
    end
  end
endmodule : csd_chan_model

// File: test/csd_engine_tb.sv
// Self-checking bench for the cycle-steal descriptor engine.
`timescale 1ns/1ps
`include "csd_params.svh"
module csd_engine_tb import csd_pkg::*; ;
  logic        mclk_i = 1'b0, rst_i = 1'b1, avs_read_i = 1'b0, avs_write_i = 1'b0, irq_hold_i = 1'b0;
  logic        exc_valid_i = 1'b0, exc_short_ilr_i = 1'b0, err_en_i = 1'b0, exc_cod_i = 1'b0;
  logic [3:0]  avs_address_i = 4'h0;
  logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o, q;
  logic [1:0]  exc_type_i = 2'h0;
  logic [7:0]  exc_flags_i = 8'h00, irq_info_o;
  logic [15:0] dv_data_i = 16'h1234, cs_addr_o, cs_wdata_o, cs_rdata_i;
  logic [2:0]  irq_cc_o;
  logic        avs_waitrequest_o, cs_req_o, cs_we_o, cs_ack_i, cs_err_i, burst_hold_o, irq_req_o, irq_ack_i, dv_ready_o;
  int          err_count = 0, total_checks = 0, n;
  always #12.5 mclk_i = ~mclk_i;
  csd_engine #(.RSB_WORDS(2)) dut_u (.mclk_i, .rst_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
    .avs_byteenable_i(4'hf), .avs_readdata_o, .avs_waitrequest_o, .cs_req_o, .cs_we_o, .cs_addr_o, .cs_wdata_o,
    .cs_ack_i, .cs_err_i, .cs_rdata_i, .burst_hold_o, .irq_req_o, .irq_cc_o, .irq_info_o, .irq_ack_i,
    .dv_valid_i(1'b1), .dv_data_i, .dv_ready_o, .exc_valid_i, .exc_type_i, .exc_flags_i, .exc_short_ilr_i,
    .exc_cod_i);
  csd_chan_model chan_u (.mclk_i, .rst_i, .irq_hold_i, .err_en_i, .cs_req_i(cs_req_o), .cs_we_i(cs_we_o),
    .cs_addr_i(cs_addr_o), .cs_wdata_i(cs_wdata_o), .burst_hold_i(burst_hold_o), .irq_req_i(irq_req_o),
    .cs_ack_o(cs_ack_i), .cs_err_o(cs_err_i), .cs_rdata_o(cs_rdata_i), .irq_ack_o(irq_ack_i));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic avs(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    {avs_address_i, avs_writedata_i, avs_write_i, avs_read_i} <= {a, d, w, !w};
    // Waitrequest and read data are taken as they stand at the edge itself.
    for (n = 0; n < 50; n++) begin
      @(posedge mclk_i);
      if (avs_waitrequest_o === 1'b0) break;
    end
    if (n >= 50) err_count++;
    q = avs_readdata_o;
    {avs_write_i, avs_read_i} <= 2'h0;
  endtask : avs
  task automatic wt_irq(input logic v);
    for (n = 0; irq_req_o !== v && n < 4000; n++) @(posedge mclk_i);
    if (n >= 4000) err_count++;
    #1;
  endtask : wt_irq
  task automatic irq(input string nm, input logic [2:0] cc, input logic [7:0] info, input logic [7:0] mask);
    wt_irq(1'b1);
    chk(nm, {cc, info & mask}, {irq_cc_o, irq_info_o & mask});
    wt_irq(1'b0);
    repeat (4) @(posedge mclk_i);
  endtask : irq
  // Word b of storage holds the descriptor; its status block sits at word 16'h200 + b, data at byte 16'h0300.
  task automatic go(input int b, input logic [15:0] c, input logic [15:0] nx, input logic [15:0] k);
    chan_u.mem[b] = c;
    chan_u.mem[b+3] = 16'h005a;
    chan_u.mem[b+4] = 16'h0400 + 16'(b * 2);
    chan_u.mem[b+5] = nx;
    chan_u.mem[b+6] = k;
    chan_u.mem[b+7] = 16'h0300;
    chan_u.mem[b+16'h201] = 16'hdead;
    chan_u.mem[16'h180] = 16'h0000;
    avs(1'b1, `CSD_REG_START, 32'(b * 2));
  endtask : go
  task automatic exc(input logic [1:0] t, input logic [7:0] f, input logic incorrect_length_record);
    for (n = 0; dv_ready_o !== 1'b1 && n < 4000; n++) @(posedge mclk_i);
    repeat (6) @(posedge mclk_i);
    {exc_valid_i, exc_type_i, exc_flags_i, exc_short_ilr_i} <= {1'b1, t, f, incorrect_length_record};
    @(posedge mclk_i);
    exc_valid_i <= 1'b0;
  endtask : exc
  task automatic wrap_up();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : wrap_up
  initial begin
    repeat (3) @(posedge mclk_i);
    rst_i <= 1'b0;
    avs(1'b0, `CSD_REG_OPT, 32'h0);
    chk("opt_reset", 32'h0, q);
    avs(1'b1, 4'h2, 32'hffff);
    avs(1'b1, `CSD_REG_OPT, 32'h1);
    avs(1'b0, `CSD_REG_OPT, 32'h0);
    chk("opt_rw", 32'h1, q);
    avs(1'b0, 4'h2, 32'h0);
    chk("unmapped", 32'h0, q);
    go(16'h80, 16'h0800, 16'h0, 16'h4);
    exc(2'h2, 8'h08, 1'b1);
    irq("ilr_end", 3'h3, 8'h00, 8'h00);
    chk("ilr_word1", 16'hc008, chan_u.mem[16'h281]);
    avs(1'b1, `CSD_REG_OPT, 32'h2);
    exc_cod_i <= 1'b1;
    go(16'h80, 16'h0800, 16'h0, 16'h4);
    exc(2'h3, 8'h20, 1'b0);
    irq("cod_end", `CSD_CC_END, 8'h00, 8'h80);
    chk("cod_word1", 16'hc020, chan_u.mem[16'h281]);
    exc_cod_i <= 1'b0;
    avs(1'b1, `CSD_REG_OPT, 32'h0);
    go(16'h80, 16'h4800, 16'h0, 16'h4);
    irq("pci", `CSD_CC_PCI, 8'h5a, 8'hff);
    irq("end_plain", `CSD_CC_END, 8'h00, 8'h80);
    chk("rsb_count", 16'h0000, chan_u.mem[16'h280]);
    chk("rsb_clean", 16'hc000, chan_u.mem[16'h281]);
    chk("data_word", 16'h1234, chan_u.mem[16'h180]);
    chan_u.mem[16'h90] = 16'h0800;
    chan_u.mem[16'h94] = 16'h0520;
    chan_u.mem[16'h97] = 16'h0300;
    go(16'h80, 16'h8800, 16'h0120, 16'h4);
    chan_u.mem[16'h96] = 16'h0002;
    exc(2'h1, 8'h01, 1'b0);
    irq("chain_pde", `CSD_CC_END, 8'h80, 8'h80);
    chk("chain_word1", 16'h0001, chan_u.mem[16'h281]);
    chk("next_count", 16'h0000, chan_u.mem[16'h290]);
    go(16'h80, 16'h0800, 16'h0, 16'h8);
    exc(2'h1, 8'h01, 1'b0);
    exc(2'h2, 8'h02, 1'b0);
    irq("txfr_pde", `CSD_CC_END, 8'h80, 8'h80);
    chk("txfr_count", 16'h0004, chan_u.mem[16'h280]);
    chk("txfr_word1", 16'h8003, chan_u.mem[16'h281]);
    chan_u.mem[16'h90] = 16'h4000;
    go(16'h80, 16'h8800, 16'h0120, 16'h8);
    exc(2'h3, 8'h04, 1'b0);
    irq("tchn_end", `CSD_CC_END, 8'h80, 8'h80);
    chk("tchn_word1", 16'h8004, chan_u.mem[16'h281]);
    go(16'h80, 16'h8800, 16'h0120, 16'h4);
    irq("chain_se_clean", `CSD_CC_END, 8'h00, 8'h80);
    chk("clean_word1", 16'hc000, chan_u.mem[16'h281]);
    go(16'h80, 16'h8000, 16'h0120, 16'h8);
    exc(2'h1, 8'h10, 1'b0);
    irq("se_off", `CSD_CC_EXC, 8'h10, 8'hff);
    chk("no_block", 16'hdead, chan_u.mem[16'h281]);
    err_en_i <= 1'b1;
    go(16'h80, 16'h0800, 16'h0, 16'h4);
    irq("fetch_err", `CSD_CC_EXC, 8'h00, 8'h00);
    err_en_i <= 1'b0;
    go(16'h80, 16'h0001, 16'h0, 16'h6);
    repeat (3) begin
      for (n = 0; dv_ready_o !== 1'b1 && n < 4000; n++) @(posedge mclk_i);
      chk("burst_hold", 1'b1, burst_hold_o);
      @(posedge mclk_i);
    end
    irq("burst_end", `CSD_CC_END, 8'h00, 8'h80);
    irq_hold_i <= 1'b1;
    go(16'h80, 16'h4000, 16'h0, 16'h4);
    wt_irq(1'b1);
    chk("pci_pending", 4'h9, {irq_req_o, irq_cc_o});
    for (n = 0; irq_cc_o !== `CSD_CC_END && n < 4000; n++) @(posedge mclk_i);
    chk("pci_replaced", 4'hb, {irq_req_o, irq_cc_o});
    avs(1'b0, `CSD_REG_RESID, 32'h0);
    chk("xfer_while_pending", 16'h0000, q[15:0]);
    irq_hold_i <= 1'b0;
    wt_irq(1'b0);
    wrap_up();
  end
  // Longest scenario is a few hundred cycles; twenty thousand leaves ample margin.
  initial begin
    #500000;
    err_count++;
    wrap_up();
  end
endmodule : csd_engine_tb
